// File: hw/ast_pkg.sv
// Shared constants and types of the asynchronous serial transceiver.
// Assumes one 40 MHz clock and an 8-bit register port with 3 address bits.
package ast_pkg;

    // ========================================================
    // Register map
    localparam logic [2:0] AST_ADDR_STATUS = 3'h0;
    localparam logic [2:0] AST_ADDR_CTRL1 = 3'h1;
    localparam logic [2:0] AST_ADDR_CTRL2 = 3'h2;
    localparam logic [2:0] AST_ADDR_BAUD = 3'h3;
    localparam logic [2:0] AST_ADDR_DATA = 3'h4;
    localparam logic [7:0] AST_CTRL_RESET = 8'h00;
    localparam logic [7:0] AST_BAUD_RESET = 8'h00;
    localparam logic [7:0] AST_READ_NONE = 8'h00;

    // ========================================================
    // Bit timing: sixteen baud ticks per bit, majority of three samples
    localparam logic [3:0] AST_OVS_LAST = 4'hf;
    localparam logic [3:0] AST_MID_A = 4'h7;
    localparam logic [3:0] AST_MID_B = 4'h8;
    localparam logic [3:0] AST_MID_C = 4'h9;
    localparam logic [3:0] AST_LAST_BIT_8 = 4'h7;
    localparam logic [3:0] AST_LAST_BIT_9 = 4'h8;

    // ========================================================
    // Receive buffer
    localparam int AST_FIFO_DEPTH = 2;
    localparam logic [1:0] AST_FIFO_FULL = 2'h2;

    // ========================================================
    // Register layouts, most significant field first
    typedef struct packed {
        logic serial_unit_enable;
        logic nine_bits;
        logic parity_en;
        logic parity_odd;
        logic two_stops;
        logic send_break;
        logic rx_bit8;
        logic tx_bit8;
    } ast_ctrl1_type;

    typedef struct packed {
        logic transmitter_enable_bit;
        logic receiver_enable_bit;
        logic fast_baud;
        logic addr_detect;
        logic wake_en;
        logic rx_int_en;
        logic idle_int_en;
        logic empty_int_en;
    } ast_ctrl2_type;

    typedef struct packed {
        logic [3:0] err_flags;
        logic rx_quiet_flag;
        logic rx_buffer_full_flag;
        logic tx_complete_flag;
        logic tx_buffer_empty_flag;
    } ast_status_type;

    typedef struct packed {
        logic bit8;
        logic [7:0] data;
    } ast_char_type;

    typedef enum logic [4:0] {
        AST_S_IDLE = 5'h01,
        AST_S_START = 5'h02,
        AST_S_DATA = 5'h04,
        AST_S_PAR = 5'h08,
        AST_S_STOP = 5'h10
    } ast_state_type;

endpackage : ast_pkg

// File: hw/ast_baud_gen.sv
// Baud generator: one-cycle tick every (divisor + 1) clocks.
// Assumes divisor comes from a register on the same clock.
`timescale 1ns/100ps
module ast_baud_gen
    import ast_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic enable,
    input wire logic [7:0] divisor,
    output logic tick
);

    logic [7:0] count;

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            count <= '0;
            tick <= 1'b0;
        end
        else if (!enable)
        begin
            count <= '0;
            tick <= 1'b0;
        end
        else if (count == '0)
        begin
            count <= divisor;
            tick <= 1'b1;
        end
        else
        begin
            count <= count - 8'h01;
            tick <= 1'b0;
        end
    end

endmodule : ast_baud_gen

// File: hw/ast_serial_top.sv
// Asynchronous serial transceiver with register port and pin control.
// Assumes rx_pin is asynchronous and the register master is on ref_clk.
`timescale 1ns/100ps
module ast_serial_top
    import ast_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [2:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata,
    input wire logic rx_pin,
    output logic tx_pin,
    output logic tx_oe_n,
    output logic rx_pin_sel,
    output logic irq,
    output logic wake_req
);

    ast_ctrl1_type ctrl1;
    ast_ctrl2_type ctrl2;
    ast_status_type status_now;
    ast_state_type tx_state;
    ast_state_type rx_state;
    ast_char_type hold;
    ast_char_type fifo_mem [AST_FIFO_DEPTH];
    ast_char_type head;
    logic [7:0] baud_div;
    logic baud_tick;
    logic tx_run, rx_run, data_wr, data_rd, status_rd, armed;
    logic hold_full, tx_load, tx_bit_end, tx_par, tx_stop2;
    logic [3:0] tx_sub, tx_bitn, rx_sub, rx_bitn, last_idx;
    logic [8:0] tx_shift, rx_shift;
    logic rx_s1, rx_s2, rx_s3, rx_line;
    logic [2:0] rx_smp;
    logic bit_val, bit_noisy, rx_bit_end, rx_noisy, rx_ferr, rx_parbit;
    logic rx_done, rx_keep, rx_par_bad, push, pop, overrun_set;
    logic fifo_wp, fifo_rp;
    logic [1:0] fifo_count;
    logic [3:0] err_flags, err_set;
    logic err_clr;

    // ========================================================
    // Register port
    assign data_wr = bus_wr && bus_addr == AST_ADDR_DATA;
    assign data_rd = bus_rd && bus_addr == AST_ADDR_DATA;
    assign status_rd = bus_rd && bus_addr == AST_ADDR_STATUS;
    assign tx_run = ctrl1.serial_unit_enable && ctrl2.transmitter_enable_bit;
    assign rx_run = ctrl1.serial_unit_enable && ctrl2.receiver_enable_bit;
    assign last_idx = ctrl1.nine_bits ? AST_LAST_BIT_9 : AST_LAST_BIT_8;

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            ctrl1 <= AST_CTRL_RESET;
            ctrl2 <= AST_CTRL_RESET;
            baud_div <= AST_BAUD_RESET;
        end
        else if (bus_wr)
        begin
            // The received ninth bit is read-only and lives in the buffer.
            if (bus_addr == AST_ADDR_CTRL1)
                ctrl1 <= bus_wdata & ~8'h02;
            if (bus_addr == AST_ADDR_CTRL2)
                ctrl2 <= bus_wdata;
            if (bus_addr == AST_ADDR_BAUD)
                baud_div <= bus_wdata;
        end
    end

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            bus_rdata <= AST_READ_NONE;
        else if (!bus_rd)
            bus_rdata <= AST_READ_NONE;
        else
        begin
            case (bus_addr)
                AST_ADDR_STATUS: bus_rdata <= status_now;
                AST_ADDR_CTRL1: bus_rdata <= {ctrl1[7:2], head.bit8, 1'b0};
                AST_ADDR_CTRL2: bus_rdata <= ctrl2;
                AST_ADDR_BAUD: bus_rdata <= baud_div;
                AST_ADDR_DATA: bus_rdata <= head.data;
                default: bus_rdata <= AST_READ_NONE;
            endcase
        end
    end

    ast_baud_gen u_baud (
        .ref_clk(ref_clk),
        .reset(reset),
        .enable(ctrl1.serial_unit_enable),
        .divisor(baud_div),
        .tick(baud_tick)
    );

    // ========================================================
    // Transmit holding register
    assign tx_load = tx_run && tx_state == AST_S_IDLE && hold_full
        && baud_tick && !ctrl1.send_break;

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            hold_full <= 1'b0;
            hold <= '0;
        end
        else if (!tx_run)
            hold_full <= 1'b0;
        else if (data_wr)
        begin
            // A write beside a load wins: the old byte goes to the shifter.
            hold_full <= 1'b1;
            hold <= {ctrl1.tx_bit8, bus_wdata};
        end
        else if (tx_load)
            hold_full <= 1'b0;
    end

    // ========================================================
    // Transmit shifter
    assign tx_bit_end = baud_tick && tx_sub == AST_OVS_LAST;

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            tx_state <= AST_S_IDLE;
            tx_sub <= '0;
            tx_bitn <= '0;
            tx_shift <= '0;
            tx_par <= 1'b0;
            tx_stop2 <= 1'b0;
            tx_pin <= 1'b1;
        end
        else if (!tx_run)
        begin
            tx_state <= AST_S_IDLE;
            tx_pin <= 1'b1;
        end
        else
        begin
            if (tx_state == AST_S_IDLE)
                tx_sub <= '0;
            else if (baud_tick)
                tx_sub <= tx_sub + 4'h1;
            case (tx_state)
                AST_S_IDLE:
                begin
                    tx_pin <= !ctrl1.send_break;
                    if (tx_load)
                    begin
                        tx_shift <= {hold.bit8 & ctrl1.nine_bits, hold.data};
                        tx_par <= ^{hold.bit8 & ctrl1.nine_bits, hold.data}
                            ^ ctrl1.parity_odd;
                        tx_state <= AST_S_START;
                        tx_pin <= 1'b0;
                    end
                end
                AST_S_START:
                    if (tx_bit_end)
                    begin
                        tx_state <= AST_S_DATA;
                        tx_bitn <= '0;
                        tx_pin <= tx_shift[0];
                    end
                AST_S_DATA:
                    if (tx_bit_end && tx_bitn == last_idx)
                    begin
                        tx_state <= ctrl1.parity_en ? AST_S_PAR : AST_S_STOP;
                        tx_pin <= !ctrl1.parity_en || tx_par;
                        tx_stop2 <= 1'b0;
                    end
                    else if (tx_bit_end)
                    begin
                        tx_shift <= tx_shift >> 1;
                        tx_pin <= tx_shift[1];
                        tx_bitn <= tx_bitn + 4'h1;
                    end
                AST_S_PAR:
                    if (tx_bit_end)
                    begin
                        tx_state <= AST_S_STOP;
                        tx_pin <= 1'b1;
                    end
                AST_S_STOP:
                    if (tx_bit_end && ctrl1.two_stops && !tx_stop2)
                        tx_stop2 <= 1'b1;
                    else if (tx_bit_end)
                        tx_state <= AST_S_IDLE;
                default:
                    tx_state <= AST_S_IDLE;
            endcase
        end
    end

    // ========================================================
    // Receive pin synchroniser; a change counts once stages two and three
    // agree, which also swallows a single-cycle glitch.
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
            rx_s3 <= 1'b1;
            rx_line <= 1'b1;
        end
        else
        begin
            rx_s1 <= rx_pin;
            rx_s2 <= rx_s1;
            rx_s3 <= rx_s2;
            if (rx_s2 == rx_s3)
                rx_line <= rx_s3;
        end
    end

    // ========================================================
    // Receive shifter
    assign rx_bit_end = baud_tick && rx_sub == AST_OVS_LAST;
    assign bit_val = (rx_smp[0] & rx_smp[1]) | (rx_smp[0] & rx_smp[2])
        | (rx_smp[1] & rx_smp[2]);
    assign bit_noisy = !(&rx_smp) && |rx_smp;

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            rx_state <= AST_S_IDLE;
            rx_sub <= '0;
            rx_bitn <= '0;
            rx_smp <= '0;
            rx_shift <= '0;
            rx_noisy <= 1'b0;
            rx_ferr <= 1'b0;
            rx_parbit <= 1'b0;
            rx_done <= 1'b0;
        end
        else if (!rx_run)
        begin
            rx_state <= AST_S_IDLE;
            rx_done <= 1'b0;
        end
        else
        begin
            rx_done <= 1'b0;
            if (rx_state == AST_S_IDLE)
                rx_sub <= '0;
            else if (baud_tick)
                rx_sub <= rx_sub + 4'h1;
            if (baud_tick && rx_sub == AST_MID_A)
                rx_smp[0] <= rx_line;
            if (baud_tick && rx_sub == AST_MID_B)
                rx_smp[1] <= rx_line;
            if (baud_tick && rx_sub == AST_MID_C)
                rx_smp[2] <= rx_line;
            case (rx_state)
                AST_S_IDLE:
                    if (baud_tick && !rx_line)
                        rx_state <= AST_S_START;
                AST_S_START:
                    if (rx_bit_end)
                    begin
                        // A high majority means a glitch, not a start bit.
                        rx_state <= bit_val ? AST_S_IDLE : AST_S_DATA;
                        rx_bitn <= '0;
                        rx_noisy <= bit_noisy;
                    end
                AST_S_DATA:
                    if (rx_bit_end)
                    begin
                        rx_shift <= {bit_val, rx_shift[8:1]};
                        rx_noisy <= rx_noisy | bit_noisy;
                        if (rx_bitn == last_idx)
                            rx_state <= ctrl1.parity_en ? AST_S_PAR
                                : AST_S_STOP;
                        else
                            rx_bitn <= rx_bitn + 4'h1;
                    end
                AST_S_PAR:
                    if (rx_bit_end)
                    begin
                        rx_parbit <= bit_val;
                        rx_noisy <= rx_noisy | bit_noisy;
                        rx_state <= AST_S_STOP;
                    end
                AST_S_STOP:
                    if (rx_bit_end)
                    begin
                        // Only the first stop bit is checked on receive.
                        rx_ferr <= !bit_val;
                        rx_noisy <= rx_noisy | bit_noisy;
                        rx_done <= 1'b1;
                        rx_state <= AST_S_IDLE;
                    end
                default:
                    rx_state <= AST_S_IDLE;
            endcase
        end
    end

    // ========================================================
    // Receive buffer and flags
    assign rx_keep = !(ctrl2.addr_detect && !rx_shift[8]);
    assign rx_par_bad = ctrl1.parity_en && (ctrl1.parity_odd ^ rx_parbit
        ^ (^(ctrl1.nine_bits ? rx_shift : {1'b0, rx_shift[8:1]})));
    assign overrun_set = rx_done && rx_keep
        && (fifo_count == AST_FIFO_FULL || err_flags[0]);
    assign push = rx_done && rx_keep && !overrun_set;
    assign pop = data_rd && fifo_count != '0;
    assign head = fifo_mem[fifo_rp];

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            fifo_wp <= 1'b0;
            fifo_rp <= 1'b0;
            fifo_count <= '0;
            fifo_mem[0] <= '0;
            fifo_mem[1] <= '0;
        end
        else
        begin
            if (push)
            begin
                fifo_mem[fifo_wp].data <= ctrl1.nine_bits ? rx_shift[7:0]
                    : rx_shift[8:1];
                fifo_mem[fifo_wp].bit8 <= ctrl1.nine_bits & rx_shift[8];
                fifo_wp <= !fifo_wp;
            end
            if (pop)
                fifo_rp <= !fifo_rp;
            if (push && !pop)
                fifo_count <= fifo_count + 2'h1;
            else if (pop && !push)
                fifo_count <= fifo_count - 2'h1;
        end
    end

    // Errors: parity, noise, framing, overrun. Noise is not flagged for a
    // character lost to overrun.
    assign err_set = {push && rx_par_bad, push && rx_noisy,
        push && rx_ferr, overrun_set};
    assign err_clr = armed && (data_rd || data_wr);

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            armed <= 1'b0;
        else if (status_rd)
            armed <= 1'b1;
        else if (bus_rd || bus_wr)
            armed <= 1'b0;
    end

    generate
        for (genvar i = 0; i < 4; i++)
        begin : g_err
            always_ff @(posedge ref_clk or posedge reset)
            begin
                if (reset)
                    err_flags[i] <= 1'b0;
                else
                    err_flags[i] <= err_set[i]
                        || (err_flags[i] && !err_clr);
            end
        end
    endgenerate

    assign status_now.err_flags = err_flags;
    assign status_now.rx_quiet_flag = rx_state == AST_S_IDLE;
    assign status_now.rx_buffer_full_flag = fifo_count != '0;
    assign status_now.tx_buffer_empty_flag = !hold_full;
    assign status_now.tx_complete_flag = !hold_full
        && tx_state == AST_S_IDLE && !ctrl1.send_break;

    // ========================================================
    // Pins, interrupt and wake
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            tx_oe_n <= 1'b1;
            rx_pin_sel <= 1'b0;
            irq <= 1'b0;
            wake_req <= 1'b0;
        end
        else
        begin
            tx_oe_n <= !tx_run;
            rx_pin_sel <= rx_run;
            irq <= (ctrl2.rx_int_en && (status_now.rx_buffer_full_flag
                || err_flags[0]))
                || (ctrl2.idle_int_en && status_now.tx_complete_flag)
                || (ctrl2.empty_int_en && tx_run
                && status_now.tx_buffer_empty_flag);
            wake_req <= ctrl2.wake_en && rx_run && !rx_line;
        end
    end

    // ========================================================
    // Checks
    a_start_low: assert property (@(posedge ref_clk) disable iff (reset)
        tx_load |=> !tx_pin)
        else $error("start bit not low");
    a_stop_high: assert property (@(posedge ref_clk) disable iff (reset)
        tx_state == AST_S_STOP |-> tx_pin)
        else $error("stop bit not high");
    a_fifo_bound: assert property (@(posedge ref_clk) disable iff (reset)
        push |-> fifo_count != AST_FIFO_FULL)
        else $error("push into full buffer");
    a_overrun_full: assert property (@(posedge ref_clk) disable iff (reset)
        $rose(err_flags[0]) |-> $past(fifo_count) == AST_FIFO_FULL)
        else $error("overrun while buffer not full");
    a_tx_buffer_empty_flag_enable: assert property (@(posedge ref_clk) disable iff (reset)
        $rose(tx_run) && !$past(data_wr) |-> status_now.tx_buffer_empty_flag)
        else $error("empty flag not set on enable");
    a_rx_busy: assert property (@(posedge ref_clk) disable iff (reset)
        rx_run && rx_state == AST_S_IDLE && baud_tick && !rx_line
        |=> !status_now.rx_quiet_flag)
        else $error("quiet flag high after start");
    a_err_clear: assert property (@(posedge ref_clk) disable iff (reset)
        err_clr && err_set == '0 |=> err_flags == '0)
        else $error("errors not cleared");
    a_pin_release: assert property (@(posedge ref_clk) disable iff (reset)
        !tx_run |=> tx_oe_n && tx_pin)
        else $error("tx pin not released");
    a_data_pop: assert property (@(posedge ref_clk) disable iff (reset)
        pop && !push |=> fifo_count == $past(fifo_count) - 2'h1)
        else $error("read did not pop");

endmodule : ast_serial_top

// File: verif/ast_peer.sv
// Remote serial party: sends frames on rx_pin and captures tx_pin.
// Assumes a bit lasts BIT_CLKS cycles of ref_clk, as the device is set.
`timescale 1ns/100ps
module ast_peer
#(
    parameter int BIT_CLKS = 16
)
(
    input wire logic ref_clk,
    input wire logic tx_pin,
    output logic rx_pin
);
    // ========================================================
    // Line idles high, as a pulled-up wire would between frames.
    initial rx_pin = 1'b1;

    task automatic send_frame(input logic [9:0] bits, input int n);
        rx_pin <= 1'b0;
        repeat (BIT_CLKS) @(posedge ref_clk);
        for (int i = 0; i < n; i++)
        begin
            rx_pin <= bits[i];
            repeat (BIT_CLKS) @(posedge ref_clk);
        end
        rx_pin <= 1'b1;
        repeat (BIT_CLKS) @(posedge ref_clk);
    endtask : send_frame

    // Samples mid-bit; f[0] is the start bit. Twelve samples reach the first
    // stop bit of the longest frame, so shorter frames show idle high in the top bits.
    task automatic get_frame(output logic [11:0] f);
        @(negedge tx_pin);
        repeat (BIT_CLKS / 2) @(posedge ref_clk);
        for (int i = 0; i < 12; i++)
        begin
            f[i] = tx_pin;
            repeat (BIT_CLKS) @(posedge ref_clk);
        end
    endtask : get_frame
endmodule : ast_peer

// File: verif/tb.sv
// Self-checking bench of the serial transceiver with a remote peer.
// Assumes baud divisor 0, so one bit is 16 clocks of ref_clk.
`timescale 1ns/100ps
module tb
    import ast_pkg::*;
;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [2:0] bus_addr = 3'h0;
    logic [7:0] bus_wdata = 8'h00;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [7:0] bus_rdata;
    logic rx_pin, tx_pin, tx_oe_n, rx_pin_sel, irq, wake_req;
    logic [11:0] f;
    int mismatches = 0;
    int n_compared = 0;

    always #12.5 ref_clk = ~ref_clk;

    ast_serial_top DUT (.ref_clk(ref_clk), .reset(reset),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_rdata(bus_rdata), .rx_pin(rx_pin),
        .tx_pin(tx_pin), .tx_oe_n(tx_oe_n), .rx_pin_sel(rx_pin_sel),
        .irq(irq), .wake_req(wake_req));
    ast_peer #(.BIT_CLKS(16)) peer (.ref_clk(ref_clk), .tx_pin(tx_pin),
        .rx_pin(rx_pin));

    // ========================================================
    // Bus and compare helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge ref_clk);
        bus_wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe.
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp,
        input logic [7:0] mask);
        @(posedge ref_clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge ref_clk);
        bus_rd <= 1'b0;
        #1 chk(bus_rdata & mask, exp);
    endtask : rd_chk

    task automatic settle;
        repeat (12) @(posedge ref_clk);
    endtask : settle

    task automatic complete_run;
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run

    // ========================================================
    // Scenarios
    task automatic test_reset;
        rd_chk(AST_ADDR_STATUS, 8'h0b, 8'hff);
        rd_chk(AST_ADDR_CTRL2, 8'h00, 8'hff);
        rd_chk(3'h7, 8'h00, 8'hff);
        chk({7'h00, tx_oe_n}, 8'h01);
        $display("test_reset done");
    endtask : test_reset

    task automatic test_tx;
        wr(AST_ADDR_CTRL1, 8'h80);
        wr(AST_ADDR_BAUD, 8'h00);
        wr(AST_ADDR_CTRL2, 8'h80);
        rd_chk(AST_ADDR_STATUS, 8'h03, 8'h03);
        chk({6'h00, tx_oe_n, rx_pin_sel}, 8'h00);
        fork
            peer.get_frame(f);
            wr(AST_ADDR_DATA, 8'ha5);
        join
        chk(f[8:1], 8'ha5);
        chk({6'h00, f[9], f[0]}, 8'h02);
        settle();
        rd_chk(AST_ADDR_STATUS, 8'h03, 8'h03);
        $display("test_tx done");
    endtask : test_tx

    // Three characters without a read: the third must overrun.
    task automatic test_rx;
        wr(AST_ADDR_CTRL2, 8'hcc);
        settle();
        chk({6'h00, rx_pin_sel, wake_req}, 8'h02);
        fork
            peer.send_frame({2'b00, 8'h3c}, 8);
            begin
                repeat (8) @(posedge ref_clk);
                chk({7'h00, wake_req}, 8'h01);
            end
        join
        settle();
        rd_chk(AST_ADDR_STATUS, 8'h04, 8'h04);
        chk({7'h00, irq}, 8'h01);
        peer.send_frame({2'b00, 8'hc3}, 8);
        peer.send_frame({2'b00, 8'h5a}, 8);
        settle();
        rd_chk(AST_ADDR_STATUS, 8'h14, 8'hd4);
        rd_chk(AST_ADDR_DATA, 8'h3c, 8'hff);
        rd_chk(AST_ADDR_STATUS, 8'h04, 8'h14);
        rd_chk(AST_ADDR_DATA, 8'hc3, 8'hff);
        rd_chk(AST_ADDR_STATUS, 8'h00, 8'h04);
        $display("test_rx done");
    endtask : test_rx

    // Even parity: a wrong bit is flagged, a right one is not.
    task automatic test_parity;
        wr(AST_ADDR_CTRL1, 8'ha0);
        peer.send_frame({2'b00, 8'h01}, 9);
        settle();
        rd_chk(AST_ADDR_STATUS, 8'h80, 8'h80);
        rd_chk(AST_ADDR_DATA, 8'h01, 8'hff);
        peer.send_frame({2'b00, 8'h03}, 9);
        settle();
        rd_chk(AST_ADDR_STATUS, 8'h04, 8'h84);
        rd_chk(AST_ADDR_DATA, 8'h03, 8'hff);
        $display("test_parity done");
    endtask : test_parity

    // Address detect: a character whose last bit is zero is dropped.
    task automatic test_addr;
        wr(AST_ADDR_CTRL1, 8'h80);
        wr(AST_ADDR_CTRL2, 8'hd4);
        peer.send_frame({2'b00, 8'h01}, 8);
        settle();
        rd_chk(AST_ADDR_STATUS, 8'h00, 8'h04);
        chk({7'h00, irq}, 8'h00);
        peer.send_frame({2'b00, 8'h81}, 8);
        settle();
        chk({7'h00, irq}, 8'h01);
        rd_chk(AST_ADDR_DATA, 8'h81, 8'hff);
        $display("test_addr done");
    endtask : test_addr

    // Nine bits, odd parity, two stops; the second stop keeps it busy.
    task automatic test_tx9;
        wr(AST_ADDR_CTRL1, 8'hf9);
        wr(AST_ADDR_CTRL2, 8'h82);
        fork
            peer.get_frame(f);
            wr(AST_ADDR_DATA, 8'h0f);
        join
        chk(f[8:1], 8'h0f);
        chk({5'h00, f[11:9]}, 8'h05);
        chk({7'h00, irq}, 8'h00);
        rd_chk(AST_ADDR_STATUS, 8'h00, 8'h02);
        settle();
        rd_chk(AST_ADDR_STATUS, 8'h02, 8'h02);
        chk({7'h00, irq}, 8'h01);
        wr(AST_ADDR_CTRL1, 8'h84);
        settle();
        chk({7'h00, tx_pin}, 8'h00);
        rd_chk(AST_ADDR_STATUS, 8'h00, 8'h02);
        $display("test_tx9 done");
    endtask : test_tx9

    // ========================================================
    // Main sequence and watchdog
    initial
    begin
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        test_reset();
        test_tx();
        test_rx();
        test_parity();
        test_addr();
        test_tx9();
        complete_run();
    end

    // About 1750 clocks are needed; the limit leaves ample margin.
    initial
    begin
        #200000;
        mismatches++;
        complete_run();
    end
endmodule : tb
